/* File: hw/pbc_pkg.sv */
package pbc_pkg;

  // ----------------------------------------------------------------
  // clock and timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS = 40;
  localparam int unsigned SHORT_RESET_NS = 1300;
  localparam int unsigned STATE_TIMEOUT_NS_DEF = 200000;
  localparam logic [1:0] STRAP_SETTLE = 2'h3;

  // ----------------------------------------------------------------
  // register indices, byte address is four times the index
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W = 8;
  localparam logic [3:0] IDX_REPEATER = 4'h3;
  localparam logic [3:0] IDX_SELF_ID = 4'h4;
  localparam logic [3:0] IDX_EVENT = 4'h5;
  localparam logic [3:0] IDX_IRQ_STATUS = 4'h8;
  localparam logic [3:0] IDX_IRQ_CLEAR = 4'h9;
  localparam logic [3:0] IDX_IRQ_ENABLE = 4'ha;
  localparam logic [3:0] IDX_PORT_MASK = 4'hb;

  // ----------------------------------------------------------------
  // field layout and fixed values
  // ----------------------------------------------------------------
  localparam int unsigned NUM_PORTS = 6;
  localparam logic [2:0] PHY_SPEED_VAL = 3'h2;
  localparam logic [3:0] REP_DELAY_VAL = 4'h0;
  localparam logic [2:0] REP_JITTER_VAL = 3'h0;
  localparam int unsigned REP_SPEED_LSB = 5;
  localparam int unsigned SID_L_BIT = 7;
  localparam int unsigned SID_C_BIT = 6;
  localparam int unsigned SID_JIT_LSB = 3;
  localparam int unsigned EV_RESUME_EN_BIT = 7;
  localparam int unsigned EV_SHORT_RST_BIT = 6;
  localparam int unsigned FLAG_LSB = 2;
  localparam int unsigned FLAG_W = 4;
  localparam int unsigned EV_FAST_ARB_BIT = 1;
  localparam int unsigned EV_MIXED_BIT = 0;
  // flag vector order: 3 config timeout, 2 supply drop, 1 state timeout, 0 port event
  localparam int unsigned FL_CFG = 3;
  localparam int unsigned FL_SUPPLY = 2;
  localparam int unsigned FL_STATE = 1;
  localparam int unsigned FL_PORT = 0;

  // ----------------------------------------------------------------
  // values after hardware reset
  // ----------------------------------------------------------------
  localparam logic NODE_UP_RST = 1'b1;
  localparam logic [3:0] FLAG_RST = 4'h0;

  // ----------------------------------------------------------------
  // types and helpers
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    TMO_IDLE = 2'b00,
    TMO_RUN = 2'b01,
    TMO_DONE = 2'b10
  } pbc_tmo_state_t;

  // round a time up to whole clock cycles, at least one
  function automatic int unsigned ns_to_cycles(input int unsigned ns);
    int unsigned c;
    c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    return (c == 0) ? 1 : c;
  endfunction : ns_to_cycles

  localparam int unsigned SHORT_RESET_CYC = ns_to_cycles(SHORT_RESET_NS);

endpackage : pbc_pkg

/* File: hw/pbc_tmo_if.sv */
`timescale 1ns/10ps
// configuration watchdog hookup between the register bank and its timer
interface pbc_tmo_if;
  logic busy;
  logic expire;
  modport timer (input busy, output expire);
  modport ctrl (output busy, input expire);
endinterface : pbc_tmo_if

/* File: hw/pbc_sync.sv */
`timescale 1ns/10ps
module pbc_sync #(
  parameter int unsigned W = 1
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);

  logic [W-1:0] stage1_reg;

  // two flops, the first is read by the second only
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stage1_reg <= '0;
      sync_out <= '0;
    end else begin
      stage1_reg <= async_in;
      sync_out <= stage1_reg;
    end
  end

endmodule : pbc_sync

/* File: hw/pbc_tmo_timer.sv */
`timescale 1ns/10ps
module pbc_tmo_timer #(
  parameter int unsigned LIMIT = 5000
) (
  input wire logic pclk,
  input wire logic presetn,
  pbc_tmo_if.timer tmo
);

  pbc_pkg::pbc_tmo_state_t state_reg;
  logic [31:0] count_reg;

  // one expiry per configuration phase, re-armed when busy drops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= pbc_pkg::TMO_IDLE;
      count_reg <= 32'h0;
      tmo.expire <= 1'b0;
    end else begin
      tmo.expire <= 1'b0;
      case (state_reg)
        pbc_pkg::TMO_IDLE: begin
          count_reg <= 32'h0;
          if (tmo.busy) begin
            state_reg <= pbc_pkg::TMO_RUN;
          end
        end
        pbc_pkg::TMO_RUN: begin
          if (!tmo.busy) begin
            state_reg <= pbc_pkg::TMO_IDLE;
          end else if (count_reg == 32'(LIMIT - 1)) begin
            tmo.expire <= 1'b1;
            state_reg <= pbc_pkg::TMO_DONE;
          end else begin
            count_reg <= count_reg + 32'h1;
          end
        end
        pbc_pkg::TMO_DONE: begin
          if (!tmo.busy) begin
            state_reg <= pbc_pkg::TMO_IDLE;
          end
        end
        default: begin
          state_reg <= pbc_pkg::TMO_IDLE;
        end
      endcase
    end
  end

endmodule : pbc_tmo_timer

/* File: hw/pbc_regs.sv */
// Added by the designer: the register offsets and register access over APB.
`timescale 1ns/10ps
// Notes on behaviour
// RL1 - repeater delay field is read only and always reads zero
// RL2 - repeater jitter field is read only and always reads zero
// RL3 - node-up bit is one after hardware reset, kept over bus-reset
// RL4 - self-ID link-active equals node-up AND synchronised link power input
// RL5 - contender bit loads from strap at reset, kept over bus-reset, drives self-ID
// RL6 - power class loads from three straps, kept over bus-reset, drives self-ID
// RL7 - resume enable lets resume start on any port set port event flag
// RL8 - writing one requests a short arbitrated bus-reset; bus-reset clears request
// RL9 - arbiter configuration timeout sets flag; reset or write one clears it
// RL10 - each falling edge of cable supply sense sets supply drop flag
// RL11 - a state time-out sets state timeout flag; reset or write one clears
// RL12 - stuck tree-ID or self-ID times out, sets flag and requests bus-reset
// RL13 - masked port status change sets port event flag; write one clears
// RL14 - fast arbitration enable, zero after reset, kept over bus-reset
// RL15 - software sets fast arbitration only with a compliant link controller
// RL16 - mixed-speed concatenation enable, zero after reset, kept over bus-reset
// RL17 - writing zero leaves flags alone; a same-cycle event beats the clear
module pbc_regs #(
  parameter int unsigned STATE_TIMEOUT_NS = pbc_pkg::STATE_TIMEOUT_NS_DEF
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [pbc_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic contender_strap_pin,
  input wire logic [2:0] power_class_straps,
  input wire logic link_power_input,
  input wire logic cable_supply_sense,
  input wire logic bus_reset,
  input wire logic config_timeout_event,
  input wire logic config_in_progress,
  input wire logic [pbc_pkg::NUM_PORTS-1:0] port_resume_start,
  input wire logic [pbc_pkg::NUM_PORTS-1:0] port_connected,
  input wire logic [pbc_pkg::NUM_PORTS-1:0] port_bias,
  input wire logic [pbc_pkg::NUM_PORTS-1:0] port_disabled,
  input wire logic [pbc_pkg::NUM_PORTS-1:0] port_fault,
  output logic selfid_link_active,
  output logic selfid_contender,
  output logic [2:0] selfid_power_class,
  output logic short_reset_request,
  output logic state_timeout_reset,
  output logic fast_arbitration_enable,
  output logic mixed_speed_concat_enable,
  output logic irq
);

  // ----------------------------------------------------------------
  // constants
  // ----------------------------------------------------------------
  localparam int unsigned STATE_TIMEOUT_CYC = pbc_pkg::ns_to_cycles(STATE_TIMEOUT_NS);
  localparam int unsigned NP = pbc_pkg::NUM_PORTS;

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  logic [5:0] pins_sync;
  logic cps_s;
  logic lps_s;
  logic contender_s;
  logic [2:0] power_class_s;
  logic cps_prev_reg;
  logic cps_fall;
  logic [1:0] strap_cnt_reg;
  logic strap_load;
  logic node_up_reg;
  logic contender_reg;
  logic [2:0] power_class_reg;
  logic resume_en_reg;
  logic short_reset_reg;
  logic fast_arb_reg;
  logic mixed_speed_reg;
  logic [pbc_pkg::FLAG_W-1:0] flags_reg;
  logic [pbc_pkg::FLAG_W-1:0] flags_next;
  logic [pbc_pkg::FLAG_W-1:0] flag_set;
  logic [pbc_pkg::FLAG_W-1:0] flag_clr;
  logic [pbc_pkg::FLAG_W-1:0] irq_enable_reg;
  logic [NP-1:0] port_mask_reg;
  logic [NP-1:0] con_prev_reg;
  logic [NP-1:0] bias_prev_reg;
  logic [NP-1:0] dis_prev_reg;
  logic [NP-1:0] fault_prev_reg;
  logic port_change;
  logic [3:0] acc_idx;
  logic acc_ok;
  logic setup_phase;
  logic wr_strobe;
  logic [31:0] prdata_reg;
  logic [7:0] rd_value;

  pbc_tmo_if tmo ();

  // ----------------------------------------------------------------
  // helper functions
  // ----------------------------------------------------------------

  // register index from a byte address
  function automatic logic [3:0] addr_index(input logic [pbc_pkg::ADDR_W-1:0] a);
    return a[5:2];
  endfunction : addr_index

  // address hits one of the mapped words
  function automatic logic addr_mapped(input logic [pbc_pkg::ADDR_W-1:0] a);
    logic [3:0] i;
    logic hit;
    i = a[5:2];
    hit = (i == pbc_pkg::IDX_REPEATER) || (i == pbc_pkg::IDX_SELF_ID) ||
          (i == pbc_pkg::IDX_EVENT) || (i == pbc_pkg::IDX_IRQ_STATUS) ||
          (i == pbc_pkg::IDX_IRQ_CLEAR) || (i == pbc_pkg::IDX_IRQ_ENABLE) ||
          (i == pbc_pkg::IDX_PORT_MASK);
    return hit && (a[1:0] == 2'h0) && (a[pbc_pkg::ADDR_W-1:6] == '0);
  endfunction : addr_mapped

  // ----------------------------------------------------------------
  // pin synchronisers and strap capture
  // ----------------------------------------------------------------
  pbc_sync #(
    .W(6)
  ) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .async_in({link_power_input, cable_supply_sense, power_class_straps, contender_strap_pin}),
    .sync_out(pins_sync)
  );

  assign lps_s = pins_sync[5];
  assign cps_s = pins_sync[4];
  assign power_class_s = pins_sync[3:1];
  assign contender_s = pins_sync[0];

  // straps are loaded once the synchroniser holds real pin values
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      strap_cnt_reg <= 2'h0;
    end else if (strap_cnt_reg != pbc_pkg::STRAP_SETTLE) begin
      strap_cnt_reg <= strap_cnt_reg + 2'h1;
    end
  end

  assign strap_load = (strap_cnt_reg == pbc_pkg::STRAP_SETTLE - 2'h1);

  // supply sense falling edge, read from the synchronised level
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cps_prev_reg <= 1'b0;
    end else begin
      cps_prev_reg <= cps_s;
    end
  end

  assign cps_fall = cps_prev_reg & ~cps_s; // [RL10]

  // ----------------------------------------------------------------
  // configuration watchdog
  // ----------------------------------------------------------------
  assign tmo.busy = config_in_progress;

  pbc_tmo_timer #(
    .LIMIT(STATE_TIMEOUT_CYC)
  ) u_timer (
    .pclk(pclk),
    .presetn(presetn),
    .tmo(tmo)
  );

  assign state_timeout_reset = tmo.expire; // [RL12]

  // ----------------------------------------------------------------
  // apb slave decode
  // ----------------------------------------------------------------
  assign acc_idx = addr_index(paddr);
  assign acc_ok = addr_mapped(paddr);
  assign setup_phase = psel & ~penable;
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~acc_ok;
  assign wr_strobe = psel & penable & pwrite & acc_ok;

  // read value of the addressed word
  always_comb begin
    rd_value = 8'h0;
    case (acc_idx)
      pbc_pkg::IDX_REPEATER: begin
        rd_value = {pbc_pkg::PHY_SPEED_VAL, 1'b0, pbc_pkg::REP_DELAY_VAL}; // [RL1]
      end
      pbc_pkg::IDX_SELF_ID: begin
        rd_value = {node_up_reg, contender_reg, pbc_pkg::REP_JITTER_VAL, // [RL2]
                    power_class_reg};
      end
      pbc_pkg::IDX_EVENT: begin
        rd_value = {resume_en_reg, short_reset_reg, flags_reg, fast_arb_reg, mixed_speed_reg};
      end
      pbc_pkg::IDX_IRQ_STATUS: begin
        rd_value = {2'h0, flags_reg, 2'h0};
      end
      pbc_pkg::IDX_IRQ_ENABLE: begin
        rd_value = {2'h0, irq_enable_reg, 2'h0};
      end
      pbc_pkg::IDX_PORT_MASK: begin
        rd_value = {2'h0, port_mask_reg};
      end
      default: begin
        rd_value = 8'h0;
      end
    endcase
  end

  // read data captured in the setup cycle, zero for unmapped words
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg <= 32'h0;
    end else if (setup_phase && !pwrite) begin
      prdata_reg <= acc_ok ? {24'h0, rd_value} : 32'h0;
    end
  end

  assign prdata = prdata_reg;

  // ----------------------------------------------------------------
  // self-ID configuration word
  // ----------------------------------------------------------------

  // node-up survives bus-reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      node_up_reg <= pbc_pkg::NODE_UP_RST; // [RL3]
    end else if (wr_strobe && acc_idx == pbc_pkg::IDX_SELF_ID) begin
      node_up_reg <= pwdata[pbc_pkg::SID_L_BIT];
    end
  end

  // contender and power class from straps, then software
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      contender_reg <= 1'b0;
      power_class_reg <= 3'h0;
    end else if (strap_load) begin
      contender_reg <= contender_s; // [RL5]
      power_class_reg <= power_class_s; // [RL6]
    end else if (wr_strobe && acc_idx == pbc_pkg::IDX_SELF_ID) begin
      contender_reg <= pwdata[pbc_pkg::SID_C_BIT];
      power_class_reg <= pwdata[2:0];
    end
  end

  // link-active bit for the self-ID packet
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      selfid_link_active <= 1'b0;
    end else begin
      selfid_link_active <= node_up_reg & lps_s; // [RL4]
    end
  end

  assign selfid_contender = contender_reg; // [RL5]
  assign selfid_power_class = power_class_reg; // [RL6]

  // ----------------------------------------------------------------
  // feature control and short reset request
  // ----------------------------------------------------------------

  // enables ignore bus-reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      resume_en_reg <= 1'b0; // [RL7]
      fast_arb_reg <= 1'b0; // [RL14]
      mixed_speed_reg <= 1'b0; // [RL16]
    end else if (wr_strobe && acc_idx == pbc_pkg::IDX_EVENT) begin
      resume_en_reg <= pwdata[pbc_pkg::EV_RESUME_EN_BIT];
      fast_arb_reg <= pwdata[pbc_pkg::EV_FAST_ARB_BIT];
      mixed_speed_reg <= pwdata[pbc_pkg::EV_MIXED_BIT];
    end
  end

  assign fast_arbitration_enable = fast_arb_reg; // [RL14]
  assign mixed_speed_concat_enable = mixed_speed_reg; // [RL16]

  // request held until the arbiter reports a bus-reset; a new write wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      short_reset_reg <= 1'b0;
    end else if (wr_strobe && acc_idx == pbc_pkg::IDX_EVENT) begin
      short_reset_reg <= pwdata[pbc_pkg::EV_SHORT_RST_BIT]; // [RL8]
    end else if (bus_reset) begin
      short_reset_reg <= 1'b0; // [RL8]
    end
  end

  assign short_reset_request = short_reset_reg;

  // ----------------------------------------------------------------
  // port status change detection
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      con_prev_reg <= '0;
      bias_prev_reg <= '0;
      dis_prev_reg <= '0;
      fault_prev_reg <= '0;
    end else begin
      con_prev_reg <= port_connected;
      bias_prev_reg <= port_bias;
      dis_prev_reg <= port_disabled;
      fault_prev_reg <= port_fault;
    end
  end

  assign port_change = |(((port_connected ^ con_prev_reg) | (port_bias ^ bias_prev_reg) |
                          (port_disabled ^ dis_prev_reg) | (port_fault ^ fault_prev_reg)) &
                         port_mask_reg); // [RL13]

  // per-port event mask
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      port_mask_reg <= '0;
    end else if (wr_strobe && acc_idx == pbc_pkg::IDX_PORT_MASK) begin
      port_mask_reg <= pwdata[NP-1:0];
    end
  end

  // ----------------------------------------------------------------
  // event flags and interrupt
  // ----------------------------------------------------------------

  // hardware events that set flags this cycle
  always_comb begin
    flag_set = '0;
    flag_set[pbc_pkg::FL_CFG] = config_timeout_event; // [RL9]
    flag_set[pbc_pkg::FL_SUPPLY] = cps_fall; // [RL10]
    flag_set[pbc_pkg::FL_STATE] = tmo.expire; // [RL11] [RL12]
    flag_set[pbc_pkg::FL_PORT] = port_change | (resume_en_reg & (|port_resume_start)); // [RL7]
  end

  // ones written to the event word or the clear word
  always_comb begin
    flag_clr = '0;
    if (wr_strobe && (acc_idx == pbc_pkg::IDX_EVENT || acc_idx == pbc_pkg::IDX_IRQ_CLEAR)) begin
      flag_clr = pwdata[pbc_pkg::FLAG_LSB +: pbc_pkg::FLAG_W]; // [RL17]
    end
  end

  assign flags_next = flag_set | (flags_reg & ~flag_clr); // [RL17] [RL13]

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flags_reg <= pbc_pkg::FLAG_RST; // [RL9] [RL10] [RL11]
    end else begin
      flags_reg <= flags_next;
    end
  end

  // interrupt enable word
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_enable_reg <= '0;
    end else if (wr_strobe && acc_idx == pbc_pkg::IDX_IRQ_ENABLE) begin
      irq_enable_reg <= pwdata[pbc_pkg::FLAG_LSB +: pbc_pkg::FLAG_W];
    end
  end

  assign irq = |(flags_reg & irq_enable_reg);

endmodule : pbc_regs

/* File: verif/pbc_regs_monitor.sv */
`timescale 1ns/10ps
// ----------------------------------------
// port checker of the register bank
// ----------------------------------------
module pbc_regs_monitor #(
  parameter int unsigned STATE_TIMEOUT_NS = 400
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [pbc_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pslverr,
  input wire logic bus_reset,
  input wire logic config_in_progress,
  input wire logic link_power_input,
  input wire logic selfid_link_active,
  input wire logic selfid_contender,
  input wire logic [2:0] selfid_power_class,
  input wire logic short_reset_request,
  input wire logic state_timeout_reset,
  input wire logic fast_arbitration_enable,
  input wire logic mixed_speed_concat_enable
);
  localparam int LIM = (STATE_TIMEOUT_NS + 39) / 40;
  logic acc;
  logic wr_ev;
  logic wr_id;
  logic [15:0] busy_cnt;
  // access decode for the self-ID and event registers
  assign acc = psel && penable;
  assign wr_ev = acc && pwrite && paddr == 8'h14;
  assign wr_id = acc && pwrite && paddr == 8'h10;
  // cycles of unbroken configuration activity
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy_cnt <= 16'h0;
    end else begin
      busy_cnt <= config_in_progress ? busy_cnt + 16'h1 : 16'h0;
    end
  end
  default clocking dc @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_srr_set;
    wr_ev && pwdata[6] |=> short_reset_request;
  endproperty
  a_srr_set: assert property (p_srr_set) else $error("request not raised");
  property p_srr_clr;
    bus_reset && !(wr_ev && pwdata[6]) |=> !short_reset_request;
  endproperty
  a_srr_clr: assert property (p_srr_clr) else $error("request not cleared");
  property p_srr_hold;
    short_reset_request && !bus_reset && !wr_ev |=> short_reset_request;
  endproperty
  a_srr_hold: assert property (p_srr_hold) else $error("request dropped");
  property p_id_wr;
    wr_id |=> selfid_contender == $past(pwdata[6]) && selfid_power_class == $past(pwdata[2:0]);
  endproperty
  a_id_wr: assert property (p_id_wr) else $error("self-id copy wrong");
  property p_id_keep;
    bus_reset && !wr_id |=> $stable(selfid_contender) && $stable(selfid_power_class);
  endproperty
  a_id_keep: assert property (p_id_keep) else $error("self-id lost");
  property p_feat;
    wr_ev |=> fast_arbitration_enable == $past(pwdata[1])
      && mixed_speed_concat_enable == $past(pwdata[0]);
  endproperty
  a_feat: assert property (p_feat) else $error("feature write wrong");
  property p_feat_keep;
    bus_reset && !wr_ev |=> $stable({fast_arbitration_enable, mixed_speed_concat_enable});
  endproperty
  a_feat_keep: assert property (p_feat_keep) else $error("feature lost");
  property p_link_off;
    !link_power_input [*4] |=> !selfid_link_active;
  endproperty
  a_link_off: assert property (p_link_off) else $error("link active wrong");
  property p_tmo_pulse;
    state_timeout_reset |=> !state_timeout_reset;
  endproperty
  a_tmo_pulse: assert property (p_tmo_pulse) else $error("timeout pulse long");
  property p_tmo_time;
    state_timeout_reset |-> busy_cnt >= LIM - 1 && busy_cnt <= LIM + 3;
  endproperty
  a_tmo_time: assert property (p_tmo_time) else $error("timeout early or late");
  property p_ro_read;
    acc && !pwrite |-> (paddr != 8'h0c || prdata[4:0] == 5'h0)
      && (paddr != 8'h10 || prdata[5:3] == 3'h0);
  endproperty
  a_ro_read: assert property (p_ro_read) else $error("fixed field nonzero");
endmodule : pbc_regs_monitor

bind pbc_regs pbc_regs_monitor #(.STATE_TIMEOUT_NS(STATE_TIMEOUT_NS)) pbc_regs_monitor_inst (.*);

/* File: verif/pbc_arb_model.sv */
`timescale 1ns/10ps
// ----------------------------------------
// arbiter stand-in answering reset requests
// ----------------------------------------
module pbc_arb_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic short_reset_request,
  input wire logic state_timeout_reset,
  input wire logic slow,
  output logic bus_reset
);
  logic [4:0] cnt_reg;
  // wait, pulse once, then idle until the next request
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_reg <= 5'h0;
      bus_reset <= 1'b0;
    end else begin
      bus_reset <= cnt_reg == 5'h3;
      if (cnt_reg != 5'h0) begin
        cnt_reg <= cnt_reg - 5'h1;
      end else if (short_reset_request || state_timeout_reset) begin
        cnt_reg <= slow ? 5'h10 : 5'h5;
      end
    end
  end
endmodule : pbc_arb_model

/* File: verif/tb.sv */
`timescale 1ns/10ps
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin fails++; \
  $display("BAD %s exp %h got %h", nm, e, g); end end
module tb;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, slow;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, seed;
  logic contender_strap_pin, link_power_input, cable_supply_sense, bus_reset;
  logic [2:0] power_class_straps, selfid_power_class;
  logic config_timeout_event, config_in_progress, selfid_link_active, selfid_contender;
  logic short_reset_request, state_timeout_reset;
  logic fast_arbitration_enable, mixed_speed_concat_enable;
  logic [5:0] port_resume_start, port_connected, port_bias, port_disabled, port_fault;
  logic [23:0] pv;
  logic [32:0] expq[$];
  int fails, comparisons, cycles, k, n;
  assign {port_fault, port_disabled, port_bias, port_connected} = pv;
  pbc_regs #(.STATE_TIMEOUT_NS(400)) pbc_regs_inst (.*);
  pbc_arb_model pbc_arb_model_inst (.*);
  // ----------------------------------------
  // clock, timeout, helpers
  // ----------------------------------------
  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end
  // cut a hang short
  always @(posedge pclk) begin
    cycles++;
    if (cycles > 5000) begin
      fails++;
      close_out();
    end
  end
  // read results against the oldest note
  always @(posedge pclk) begin
    logic [32:0] e;
    if (psel && penable && pready && !pwrite) begin
      e = expq.pop_front();
      `CHK("read", e, {pslverr, prdata})
    end
  end
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction : xs
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     input logic [32:0] e);
    @(posedge pclk);
    if (!w) expq.push_back(e);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 33'h0);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0, {1'b0, e});
  endtask : rd
  task automatic settle(input int c);
    repeat (c) @(posedge pclk);
    #1;
  endtask : settle
  task automatic close_out;
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : close_out
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    {psel, penable, pwrite, paddr, pwdata, pv, port_resume_start, slow} = '0;
    {link_power_input, config_timeout_event, config_in_progress} = '0;
    cable_supply_sense = 1'b1;
    seed = xs(32'ha138);
    {contender_strap_pin, power_class_straps} = seed[3:0];
    presetn = 1'b0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    repeat (4) @(posedge pclk);
    rd(8'h0c, 32'h40);
    rd(8'h10, {25'h1, contender_strap_pin, 3'h0, power_class_straps});
    rd(8'h14, 32'h0);
    wr(8'h0c, 32'hff);
    rd(8'h0c, 32'h40);
    apb(1'b0, 8'h1c, 32'h0, {1'b1, 32'h0});
    apb(1'b0, 8'h0d, 32'h0, {1'b1, 32'h0});
    $display("test reset and map done");
    link_power_input <= 1'b1;
    seed = xs(seed);
    wr(8'h10, {24'h0, seed[7:0]});
    rd(8'h10, {24'h0, seed[7:6], 3'h0, seed[2:0]});
    settle(4);
    `CHK("contender", seed[6], selfid_contender)
    `CHK("pwr_class", seed[2:0], selfid_power_class)
    `CHK("link_on", seed[7], selfid_link_active)
    @(posedge pclk);
    link_power_input <= 1'b0;
    settle(5);
    `CHK("link_off", 1'b0, selfid_link_active)
    $display("test self-id done");
    wr(8'h28, 32'h3c);
    @(posedge pclk);
    config_timeout_event <= 1'b1;
    @(posedge pclk);
    config_timeout_event <= 1'b0;
    wr(8'h14, 32'h0);
    rd(8'h14, 32'h20);
    #1;
    `CHK("irq_on", 1'b1, irq)
    fork
      wr(8'h24, 32'h20);
      begin
        repeat (2) @(posedge pclk);
        config_timeout_event <= 1'b1;
        @(posedge pclk);
        config_timeout_event <= 1'b0;
      end
    join
    rd(8'h20, 32'h20);
    wr(8'h14, 32'h20);
    rd(8'h14, 32'h0);
    cable_supply_sense <= 1'b0;
    settle(5);
    `CHK("irq_cps", 1'b1, irq)
    rd(8'h20, 32'h10);
    wr(8'h24, 32'h10);
    cable_supply_sense <= 1'b1;
    rd(8'h20, 32'h0);
    k = seed[15:8] % 6;
    wr(8'h2c, 32'h1 << k);
    for (int i = 0; i < 5; i++) begin
      pv <= pv ^ (24'h1 << (i < 4 ? 6 * i + k : (k + 1) % 6));
      rd(8'h20, i < 4 ? 32'h4 : 32'h0);
      wr(8'h24, 32'h4);
    end
    for (int en = 1; en >= 0; en--) begin
      wr(8'h14, {24'h0, en[0], 7'h0});
      port_resume_start <= 6'h1 << k;
      @(posedge pclk);
      port_resume_start <= 6'h0;
      rd(8'h14, {24'h0, en[0], 4'h0, en[0], 2'h0});
      wr(8'h14, 32'h4);
    end
    $display("test events done");
    for (int s = 0; s < 2; s++) begin
      slow <= s[0];
      wr(8'h14, 32'h43);
      #1;
      `CHK("req_on", 1'b1, short_reset_request)
      for (int i = 0; i < 40 && bus_reset !== 1'b1; i++) @(posedge pclk);
      settle(2);
      `CHK("req_off", 1'b0, short_reset_request)
      rd(8'h14, 32'h3);
      rd(8'h10, {24'h0, seed[7:6], 3'h0, seed[2:0]});
    end
    $display("test short reset done");
    config_in_progress <= 1'b1;
    n = 0;
    repeat (30) begin
      settle(1);
      n += state_timeout_reset;
    end
    `CHK("tmo_pulses", 1, n)
    @(posedge pclk);
    config_in_progress <= 1'b0;
    rd(8'h14, 32'hb);
    wr(8'h28, 32'h0);
    #1;
    `CHK("irq_mask", 1'b0, irq)
    wr(8'h14, 32'h8);
    rd(8'h14, 32'h0);
    $display("test watchdog done");
    close_out();
  end
endmodule : tb
